// ---- include/csl_defs.vh ----
/*
 constants for the start-up configuration selector and lamp driver.
 assumes a 100 MHz pclk and byte addresses on an 8-bit APB paddr.
*/
// Functional notes
// - code is tens switch times ten plus units, taken once at start-up.
// - switch movement while running is ignored until the next restart.
// - fixed mode with nothing stored holds null address, no communication.
// - fixed mode later starts keep the last assigned address.
// - fixed mode refuses every software attempt to change address or mask.
// - code 0E clears address and mask, enables BootP, keeps other settings.
// - while 0E is selected, communication off and network lamp steady yellow.
// - code 0F restores all settings, address included, to factory values.
// - factory code accepts no connection; operator restarts after ready green.
// - reserved codes keep previous settings and light ready lamp red.
// - per port, green link lamp follows link presence.
// - per port, yellow activity lamp follows data transfer.
// - ready lamp green, yellow flash on update, green/yellow on faults.
// - network lamp green with connection, flashing green with address only.
// - network red on duplicate, red flash on timeout, green/red self test.
// - module lamp green, flash green, red, red flash, green/red self test.
// - sensor lamp green when present, off when low, red on overload.
// - actuator lamp green while actuator voltage present.
// - input channel lamp yellow while the input is set.
// - output channel lamp yellow when set, red on short, else off.
// - channel lamps indexed byte then bit, lamp number is byte*8+bit.
`ifndef CSL_DEFS_VH
`define CSL_DEFS_VH
`define CSL_CLK_MHZ        100
`define CSL_BLINK_MS       1000
`define CSL_SETTLE_CYC     4'h8
`define CSL_A_FLAGS        8'h00
`define CSL_A_DIR          8'h04
`define CSL_A_OUT          8'h08
`define CSL_A_IP           8'h0C
`define CSL_A_MASK         8'h10
`define CSL_A_CFG          8'h14
`define CSL_F_READY        0
`define CSL_F_FWUPD        1
`define CSL_F_TEMP         2
`define CSL_F_SELFTEST     3
`define CSL_F_CONN         4
`define CSL_F_IPCFG        5
`define CSL_F_DUPIP        6
`define CSL_F_EOTMO        7
`define CSL_F_MODCFG       8
`define CSL_F_RECERR       9
`define CSL_F_UNRECERR     10
`define CSL_FLAGS_RST      11'h000
`define CSL_CFG_REFUSED    16
`define CSL_U_FIXED        4'hA
`define CSL_U_CLEAR        4'hE
`define CSL_U_FACTORY      4'hF
`define CSL_DIGIT_MAX      4'h9
`define CSL_MANUAL_MAX     8'h32
`define CSL_DHCP_MAX       8'h9F
`define CSL_M_REMOTE       3'h0
`define CSL_M_MANUAL       3'h1
`define CSL_M_DHCP         3'h2
`define CSL_M_FIXED        3'h3
`define CSL_M_CLEAR        3'h4
`define CSL_M_FACTORY      3'h5
`define CSL_M_RESERVED     3'h6
`define CSL_NULL_IP        32'h00000000
`define CSL_PIN_W          48
`endif

// ---- src/csl_sync2.v ----
/*
 two-stage synchroniser for a bundle of pin levels.
 assumes each bit is an independent slow level; no bus coherence.
*/
module csl_sync2 #(
	parameter W = 48
) (
	// clock and reset
	input  wire         pclk,
	input  wire         presetn,
	// pins and synced copy
	input  wire [W-1:0] pin_in,
	output reg  [W-1:0] pin_sync_ff
);
	reg [W-1:0] meta_ff;

	// first stage feeds only the second stage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff     <= {W{1'b0}};
			pin_sync_ff <= {W{1'b0}};
		end else begin
			meta_ff     <= pin_in;
			pin_sync_ff <= meta_ff;
		end
	end
endmodule // csl_sync2

// ---- src/csl_blink.v ----
/*
 shared blink timer producing a half-duty phase level.
 assumes HALF_CYC is at least one; the top shortens it in simulation.
*/
module csl_blink #(
	parameter [31:0] HALF_CYC = 32'h02FAF080
) (
	// clock and reset
	input  wire pclk,
	input  wire presetn,
	// blink phase
	output reg  blink_ff
);
	reg [31:0] cnt_ff;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff   <= 32'h00000000;
			blink_ff <= 1'b0;
		end else if (cnt_ff >= HALF_CYC - 32'h00000001) begin
			cnt_ff   <= 32'h00000000;
			blink_ff <= ~blink_ff;
		end else begin
			cnt_ff <= cnt_ff + 32'h00000001;
		end
	end
endmodule // csl_blink

// ---- src/csl_lamp_ctrl.v ----
/*
 start-up configuration selector and status lamp driver with APB registers.
 assumes switch, port, supply and channel levels arrive from pins
 asynchronously; stored_* come from non-volatile storage on pclk.
*/
`include "csl_defs.vh"
module csl_lamp_ctrl #(
	parameter [31:0] BLINK_HALF =
		(`CSL_BLINK_MS * `CSL_CLK_MHZ * 1000) / 2
) (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// rotary switches
	input  wire [3:0]  tens_switch,
	input  wire [3:0]  units_switch,
	// port and supply status pins
	input  wire [1:0]  port_link,
	input  wire [1:0]  port_activity,
	input  wire        sensor_ok,
	input  wire        sensor_overload,
	input  wire        supply_range_err,
	input  wire        actuator_ok,
	// channel pins
	input  wire [15:0] chan_in,
	input  wire [15:0] chan_short,
	// stored settings
	input  wire [31:0] stored_ip,
	input  wire [31:0] stored_mask,
	input  wire        stored_bootp,
	// address handling results
	output reg  [31:0] ip_addr_ff,
	output reg  [31:0] ip_mask_ff,
	output reg         comm_en_ff,
	output reg         bootp_en_ff,
	output reg         ip_clear_req_ff,
	output reg         factory_req_ff,
	output reg         cfg_done_ff,
	// lamps
	output reg  [1:0]  port_link_lamp,
	output reg  [1:0]  port_activity_lamp,
	output reg         ready_lamp_g,
	output reg         ready_lamp_y,
	output reg         ready_lamp_r,
	output reg         net_lamp_g,
	output reg         net_lamp_y,
	output reg         net_lamp_r,
	output reg         module_lamp_g,
	output reg         module_lamp_r,
	output reg         sensor_supply_lamp_g,
	output reg         sensor_supply_lamp_r,
	output reg         actuator_supply_lamp,
	output reg  [15:0] chan_lamp_y,
	output reg  [15:0] chan_lamp_r
);
	localparam [1:0] ST_WAIT   = 2'h0;
	localparam [1:0] ST_SAMPLE = 2'h1;
	localparam [1:0] ST_RUN    = 2'h2;

	wire [47:0] pin_s;
	wire        blink;
	reg  [1:0]  st_ff;
	reg  [3:0]  settle_ff;
	reg  [7:0]  code_ff;
	reg  [2:0]  mode_ff;
	reg  [10:0] flags_ff;
	reg  [15:0] dir_ff;
	reg  [15:0] out_ff;
	reg         refused_ff;
	reg  [2:0]  nxt_mode;
	reg  [7:0]  nxt_code;
	reg  [31:0] nxt_rdata;
	reg         nxt_err;

	wire [3:0]  tens_s   = pin_s[3:0];
	wire [3:0]  units_s  = pin_s[7:4];
	wire [1:0]  link_s   = pin_s[9:8];
	wire [1:0]  actv_s   = pin_s[11:10];
	wire        sen_ok_s = pin_s[12];
	wire        sen_ov_s = pin_s[13];
	wire        rng_s    = pin_s[14];
	wire        aok_s    = pin_s[15];
	wire [15:0] din_s    = pin_s[31:16];
	wire [15:0] shrt_s   = pin_s[47:32];

	csl_sync2 #(
		.W (`CSL_PIN_W)
	) u_sync (
		.pclk        (pclk),
		.presetn     (presetn),
		.pin_in      ({chan_short, chan_in, actuator_ok, supply_range_err,
		               sensor_overload, sensor_ok, port_activity,
		               port_link, units_switch, tens_switch}),
		.pin_sync_ff (pin_s)
	);

	csl_blink #(
		.HALF_CYC (BLINK_HALF)
	) u_blink (
		.pclk     (pclk),
		.presetn  (presetn),
		.blink_ff (blink)
	);

	// code from tens times ten plus units
	always @* begin
		nxt_code = {1'b0, tens_s, 3'h0} + {3'h0, tens_s, 1'b0}
		         + {4'h0, units_s};
		nxt_mode = `CSL_M_RESERVED;
		if (tens_s == 4'h0 && units_s == `CSL_U_FIXED)
			nxt_mode = `CSL_M_FIXED;
		else if (tens_s == 4'h0 && units_s == `CSL_U_CLEAR)
			nxt_mode = `CSL_M_CLEAR;
		else if (tens_s == 4'h0 && units_s == `CSL_U_FACTORY)
			nxt_mode = `CSL_M_FACTORY;
		else if (units_s > `CSL_DIGIT_MAX)
			nxt_mode = `CSL_M_RESERVED;
		else if (nxt_code == 8'h00)
			nxt_mode = `CSL_M_REMOTE;
		else if (nxt_code <= `CSL_MANUAL_MAX)
			nxt_mode = `CSL_M_MANUAL;
		else if (nxt_code <= `CSL_DHCP_MAX)
			nxt_mode = `CSL_M_DHCP;
	end

	wire apb_set = psel & ~penable;
	wire apb_wr  = psel & penable & pwrite;
	wire ip_lock = (mode_ff == `CSL_M_FIXED);

	// start-up sequencing and address handling
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff           <= ST_WAIT;
			settle_ff       <= 4'h0;
			code_ff         <= 8'h00;
			mode_ff         <= `CSL_M_RESERVED;
			ip_addr_ff      <= `CSL_NULL_IP;
			ip_mask_ff      <= `CSL_NULL_IP;
			comm_en_ff      <= 1'b0;
			bootp_en_ff     <= 1'b0;
			ip_clear_req_ff <= 1'b0;
			factory_req_ff  <= 1'b0;
			cfg_done_ff     <= 1'b0;
		end else begin
			case (st_ff)
			ST_WAIT: begin
				// lets the synchroniser fill before the one sample
				settle_ff <= settle_ff + 4'h1;
				if (settle_ff == `CSL_SETTLE_CYC)
					st_ff <= ST_SAMPLE;
			end
			ST_SAMPLE: begin
				code_ff     <= nxt_code;
				mode_ff     <= nxt_mode;
				st_ff       <= ST_RUN;
				cfg_done_ff <= 1'b1;
				ip_addr_ff  <= stored_ip;
				ip_mask_ff  <= stored_mask;
				bootp_en_ff <= stored_bootp;
				comm_en_ff  <= 1'b1;
				case (nxt_mode)
				`CSL_M_FIXED: begin
					comm_en_ff <= (stored_ip != `CSL_NULL_IP);
				end
				`CSL_M_CLEAR: begin
					// clear address and mask, BootP on
					ip_addr_ff      <= `CSL_NULL_IP;
					ip_mask_ff      <= `CSL_NULL_IP;
					bootp_en_ff     <= 1'b1;
					ip_clear_req_ff <= 1'b1;
					comm_en_ff      <= 1'b0;
				end
				`CSL_M_FACTORY: begin
					ip_addr_ff     <= `CSL_NULL_IP;
					ip_mask_ff     <= `CSL_NULL_IP;
					bootp_en_ff    <= 1'b1;
					factory_req_ff <= 1'b1;
					comm_en_ff     <= 1'b0;
				end
				default: begin
					comm_en_ff <= 1'b1;
				end
				endcase
			end
			ST_RUN: begin
				// address writes refused in fixed mode
				if (apb_wr && !ip_lock && paddr == `CSL_A_IP)
					ip_addr_ff <= pwdata;
				if (apb_wr && !ip_lock && paddr == `CSL_A_MASK)
					ip_mask_ff <= pwdata;
			end
			default: st_ff <= ST_WAIT;
			endcase
		end
	end

	// apb registers; zero wait, data and error registered in setup
	always @* begin
		nxt_rdata = 32'h00000000;
		nxt_err   = 1'b0;
		case (paddr)
		`CSL_A_FLAGS: nxt_rdata = {21'h000000, flags_ff};
		`CSL_A_DIR:   nxt_rdata = {16'h0000, dir_ff};
		`CSL_A_OUT:   nxt_rdata = {16'h0000, out_ff};
		`CSL_A_IP:    nxt_rdata = ip_addr_ff;
		`CSL_A_MASK:  nxt_rdata = ip_mask_ff;
		`CSL_A_CFG:   nxt_rdata = {15'h0000, refused_ff,
		                           comm_en_ff, mode_ff, code_ff,
		                           3'h0, cfg_done_ff};
		default:      nxt_err = 1'b1;
		endcase
	end

	wire ip_try  = apb_wr && (paddr == `CSL_A_IP || paddr == `CSL_A_MASK);
	wire ref_set = ip_try && (ip_lock || st_ff != ST_RUN);
	wire ref_clr = apb_wr && paddr == `CSL_A_CFG
	             && pwdata[`CSL_CFG_REFUSED];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata     <= 32'h00000000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			flags_ff   <= `CSL_FLAGS_RST;
			dir_ff     <= 16'h0000;
			out_ff     <= 16'h0000;
			refused_ff <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (apb_set) begin
				prdata  <= pwrite ? 32'h00000000 : nxt_rdata;
				pslverr <= nxt_err;
			end
			if (apb_wr && paddr == `CSL_A_FLAGS)
				flags_ff <= pwdata[10:0];
			if (apb_wr && paddr == `CSL_A_DIR)
				dir_ff <= pwdata[15:0];
			if (apb_wr && paddr == `CSL_A_OUT)
				out_ff <= pwdata[15:0];
			// refused change is flagged, set beats clear
			if (ref_set)
				refused_ff <= 1'b1;
			else if (ref_clr)
				refused_ff <= 1'b0;
		end
	end

	wire f_rdy   = flags_ff[`CSL_F_READY];
	wire f_self  = flags_ff[`CSL_F_SELFTEST];
	wire f_fault = rng_s | flags_ff[`CSL_F_TEMP] | sen_ov_s;
	reg  nxt_rg;
	reg  nxt_ry;
	reg  nxt_rr;
	reg  nxt_ng;
	reg  nxt_ny;
	reg  nxt_nr;
	reg  nxt_mg;
	reg  nxt_mr;

	// network and module chains ordered self test, faults, config, normal; ready chain faults, config, normal
	always @* begin
		nxt_rg = 1'b0;
		nxt_ry = 1'b0;
		nxt_rr = 1'b0;
		if (f_fault) begin
			nxt_rg = blink;
			nxt_ry = ~blink;
		end else if (mode_ff == `CSL_M_RESERVED && cfg_done_ff) begin
			nxt_rr = 1'b1;
		end else if (flags_ff[`CSL_F_FWUPD]) begin
			nxt_ry = blink;
		end else if (f_rdy) begin
			nxt_rg = 1'b1;
		end
		nxt_ng = 1'b0;
		nxt_ny = 1'b0;
		nxt_nr = 1'b0;
		// self test and faults on network lamp
		if (!f_rdy) begin
			nxt_ng = 1'b0;
		end else if (f_self) begin
			nxt_ng = blink;
			nxt_nr = ~blink;
		end else if (flags_ff[`CSL_F_DUPIP]) begin
			nxt_nr = 1'b1;
		end else if (flags_ff[`CSL_F_EOTMO]) begin
			nxt_nr = blink;
		end else if (mode_ff == `CSL_M_CLEAR) begin
			// steady yellow while clearing code held
			nxt_ny = 1'b1;
		end else if (flags_ff[`CSL_F_CONN] && comm_en_ff) begin
			nxt_ng = 1'b1;
		end else if (flags_ff[`CSL_F_IPCFG] && comm_en_ff) begin
			nxt_ng = blink;
		end
		nxt_mg = 1'b0;
		nxt_mr = 1'b0;
		if (!f_rdy) begin
			nxt_mg = 1'b0;
		end else if (f_self) begin
			nxt_mg = blink;
			nxt_mr = ~blink;
		end else if (flags_ff[`CSL_F_UNRECERR]) begin
			nxt_mr = blink;
		end else if (flags_ff[`CSL_F_RECERR]) begin
			nxt_mr = 1'b1;
		end else if (!flags_ff[`CSL_F_MODCFG]) begin
			nxt_mg = blink;
		end else begin
			nxt_mg = 1'b1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_link_lamp       <= 2'h0;
			port_activity_lamp   <= 2'h0;
			ready_lamp_g         <= 1'b0;
			ready_lamp_y         <= 1'b0;
			ready_lamp_r         <= 1'b0;
			net_lamp_g           <= 1'b0;
			net_lamp_y           <= 1'b0;
			net_lamp_r           <= 1'b0;
			module_lamp_g        <= 1'b0;
			module_lamp_r        <= 1'b0;
			sensor_supply_lamp_g <= 1'b0;
			sensor_supply_lamp_r <= 1'b0;
			actuator_supply_lamp <= 1'b0;
		end else begin
			port_link_lamp       <= link_s;
			port_activity_lamp   <= actv_s;
			ready_lamp_g         <= nxt_rg;
			ready_lamp_y         <= nxt_ry;
			ready_lamp_r         <= nxt_rr;
			net_lamp_g           <= nxt_ng;
			net_lamp_y           <= nxt_ny;
			net_lamp_r           <= nxt_nr;
			module_lamp_g        <= nxt_mg;
			module_lamp_r        <= nxt_mr;
			// overload red wins over present green
			sensor_supply_lamp_r <= sen_ov_s;
			sensor_supply_lamp_g <= sen_ok_s & ~sen_ov_s;
			actuator_supply_lamp <= aok_s;
		end
	end

	// lamp k is byte k/8, bit k%8
	genvar k;
	generate
		for (k = 0; k < 16; k = k + 1) begin : g_chan
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					chan_lamp_y[k] <= 1'b0;
					chan_lamp_r[k] <= 1'b0;
				end else if (dir_ff[k]) begin
					chan_lamp_r[k] <= shrt_s[k];
					chan_lamp_y[k] <= out_ff[k] & ~shrt_s[k];
				end else begin
					chan_lamp_r[k] <= 1'b0;
					chan_lamp_y[k] <= din_s[k];
				end
			end
		end
	endgenerate
endmodule // csl_lamp_ctrl

// ---- sim/csl_monitor.sv ----
/*
 port checker for the lamp controller, bound to csl_lamp_ctrl.
 assumes pclk domain only and presetn asynchronous active low.
*/
module csl_monitor (
	// clock and reset
	input wire        pclk,
	input wire        presetn,
	// pin levels
	input wire [1:0]  port_link,
	input wire [1:0]  port_activity,
	input wire        sensor_overload,
	input wire        actuator_ok,
	// lamps
	input wire [1:0]  port_link_lamp,
	input wire [1:0]  port_activity_lamp,
	input wire        sensor_supply_lamp_g,
	input wire        sensor_supply_lamp_r,
	input wire        actuator_supply_lamp,
	// address handling
	input wire [31:0] ip_addr_ff,
	input wire        comm_en_ff,
	input wire        ip_clear_req_ff,
	input wire        factory_req_ff,
	input wire        cfg_done_ff
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// settle edges are counted from the first edge after release
	sequence s_settle;
		!cfg_done_ff [*8];
	endsequence
	sequence s_sample;
		!cfg_done_ff ##1 cfg_done_ff;
	endsequence
	chk_sample_time: assert property (
		$rose(presetn) |-> s_settle ##2 s_sample) else $error("late sample");
	chk_code_frozen: assert property (cfg_done_ff |=> cfg_done_ff &&
		$stable(ip_clear_req_ff) && $stable(factory_req_ff))
		else $error("code moved");
	chk_clear_null: assert property (ip_clear_req_ff |->
		ip_addr_ff == 32'h0 && !comm_en_ff) else $error("clear mode");
	chk_factory_off: assert property (factory_req_ff |->
		ip_addr_ff == 32'h0 && !comm_en_ff) else $error("factory mode");
	chk_link_lamp: assert property (cfg_done_ff |->
		port_link_lamp == $past(port_link, 3)) else $error("link lamp");
	chk_act_lamp: assert property (cfg_done_ff |->
		port_activity_lamp == $past(port_activity, 3))
		else $error("activity lamp");
	chk_sensor_red: assert property (cfg_done_ff &&
		$past(sensor_overload, 3) |-> sensor_supply_lamp_r &&
		!sensor_supply_lamp_g) else $error("sensor lamp");
	chk_actuator_lamp: assert property (cfg_done_ff |->
		actuator_supply_lamp == $past(actuator_ok, 3))
		else $error("actuator lamp");
endmodule // csl_monitor

bind csl_lamp_ctrl csl_monitor u_mon (.*);

// ---- sim/csl_panel.sv ----
/*
 operator panel model: two rotary digits and the operator watching
 the ready lamp. assumes the bench sets digits around restarts, and once while running in t_clear.
*/
module csl_panel (
	// clock
	input wire         pclk,
	// operator choice
	input wire  [3:0]  tens_set,
	input wire  [3:0]  units_set,
	// lamp seen
	input wire         ready_lamp_g,
	// switch pins and restart go-ahead
	output logic [3:0] tens_switch,
	output logic [3:0] units_switch,
	output logic       restart_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge pclk) begin
		tens_switch <= tens_set;
		units_switch <= units_set;
	end
	assign restart_ok = ready_lamp_g;
endmodule // csl_panel

// ---- sim/tb_config_switch_status_lamps.sv ----
/*
 self-checking bench for csl_lamp_ctrl with the panel model.
 assumes zero-wait apb and a blink half period of four cycles.
*/
module tb_config_switch_status_lamps;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, stored_bootp = 1'h0, sensor_ok = 1'h0;
	logic sensor_overload = 1'h0, supply_range_err = 1'h0;
	logic actuator_ok = 1'h0, e, g0, pready, pslverr, comm_en_ff;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, stored_ip = 32'h0, stored_mask = 32'h0;
	logic [31:0] prdata, ip_addr_ff, ip_mask_ff, q;
	logic [3:0] tens_set = 4'h0, units_set = 4'h0;
	logic [3:0] tens_switch, units_switch;
	logic [1:0] port_link = 2'h0, port_activity = 2'h0;
	logic [1:0] port_link_lamp, port_activity_lamp;
	logic [15:0] chan_in = 16'h0, chan_short = 16'h0;
	logic [15:0] chan_lamp_y, chan_lamp_r;
	logic bootp_en_ff, ip_clear_req_ff, factory_req_ff, cfg_done_ff;
	logic ready_lamp_g, ready_lamp_y, ready_lamp_r, net_lamp_g;
	logic net_lamp_y, net_lamp_r, module_lamp_g, module_lamp_r;
	logic sensor_supply_lamp_g, sensor_supply_lamp_r;
	logic actuator_supply_lamp, restart_ok;
	int n_errors = 0, total_checks = 0, cyc = 0;
	always #5 pclk = ~pclk;
	csl_lamp_ctrl #(.BLINK_HALF(32'h4)) DUT (.*);
	csl_panel PNL (.*);
	task close_out;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// a hang ends in the same report
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors = n_errors + 1;
			close_out();
		end
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", n, x, s);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// restart: switches move only while reset is held
	task boot(input logic [3:0] t, input logic [3:0] u);
		@(posedge pclk);
		presetn <= 1'h0;
		tens_set <= t;
		units_set <= u;
		tick(6);
		presetn <= 1'h1;
		tick(12);
		chk("done", cfg_done_ff, 1);
	endtask
	task t_codes;
		logic [3:0] tt [3] = '{4'h0, 4'h2, 4'h6};
		logic [3:0] uu [3] = '{4'h0, 4'h3, 4'h0};
		logic [2:0] mm [3] = '{3'h0, 3'h1, 3'h2};
		for (int i = 0; i < 3; i++) begin
			boot(tt[i], uu[i]);
			apb(1'h0, 8'h14, 32'h0);
			chk("mode", q[14:12], mm[i]);
			chk("code", q[11:4], tt[i] * 10 + uu[i]);
		end
		$display("codes end");
	endtask
	task t_fixed;
		stored_ip <= 32'hC0A80007;
		boot(4'h0, 4'hA);
		chk("ip", ip_addr_ff, 32'hC0A80007);
		chk("comm", comm_en_ff, 1);
		apb(1'h1, 8'h0C, 32'h0A000001);
		apb(1'h0, 8'h14, 32'h0);
		chk("refused", q[16], 1);
		chk("ip", ip_addr_ff, 32'hC0A80007);
		stored_ip <= 32'h0;
		boot(4'h0, 4'hA);
		chk("ip", ip_addr_ff, 0);
		chk("comm", comm_en_ff, 0);
		$display("fixed end");
	endtask
	task t_clear;
		stored_ip <= 32'h0A000002;
		stored_mask <= 32'hFFFF0000;
		boot(4'h0, 4'hE);
		chk("mask", ip_mask_ff, 0);
		chk("bootp", bootp_en_ff, 1);
		chk("comm", comm_en_ff, 0);
		apb(1'h1, 8'h00, 32'h1);
		units_set <= 4'h0;
		tick(6);
		chk("nety", net_lamp_y, 1);
		chk("clr", ip_clear_req_ff, 1);
		$display("clear end");
	endtask
	task t_factory;
		boot(4'h0, 4'hF);
		chk("fac", factory_req_ff, 1);
		chk("rdyoff", {ready_lamp_g, ready_lamp_y, ready_lamp_r}, 0);
		chk("netoff", {net_lamp_g, net_lamp_y, net_lamp_r}, 0);
		chk("modoff", {module_lamp_g, module_lamp_r}, 0);
		apb(1'h1, 8'h00, 32'h1);
		tick(2);
		chk("rdyg", ready_lamp_g, 1);
		chk("opok", restart_ok, 1);
		apb(1'h1, 8'h00, 32'h3);
		tick(2);
		g0 = ready_lamp_y;
		tick(4);
		chk("fwy", ready_lamp_y, !g0);
		chk("fwg", ready_lamp_g, 0);
		apb(1'h1, 8'h00, 32'h5);
		tick(2);
		chk("temp", ready_lamp_g ^ ready_lamp_y, 1);
		$display("factory end");
	endtask
	task t_reserved;
		boot(4'h1, 4'hB);
		chk("ip", ip_addr_ff, 32'h0A000002);
		apb(1'h1, 8'h00, 32'h1);
		tick(2);
		chk("rdyr", ready_lamp_r, 1);
		$display("reserved end");
	endtask
	task t_chan;
		apb(1'h1, 8'h04, 32'hFF);
		apb(1'h1, 8'h08, 32'h5);
		chan_in <= 16'h0302;
		chan_short <= 16'h0004;
		tick(4);
		chk("chy", chan_lamp_y, 16'h0301);
		chk("chr", chan_lamp_r, 16'h0004);
		$display("chan end");
	endtask
	task t_lamps;
		port_link <= 2'h2;
		port_activity <= 2'h1;
		sensor_ok <= 1'h1;
		actuator_ok <= 1'h1;
		tick(4);
		chk("link", port_link_lamp, 2'h2);
		chk("activity", port_activity_lamp, 2'h1);
		chk("sg", sensor_supply_lamp_g, 1);
		chk("actuator", actuator_supply_lamp, 1);
		sensor_overload <= 1'h1;
		tick(4);
		chk("sr", sensor_supply_lamp_r, 1);
		chk("rdyf", ready_lamp_g ^ ready_lamp_y, 1);
		sensor_overload <= 1'h0;
		supply_range_err <= 1'h1;
		tick(4);
		chk("sr0", sensor_supply_lamp_r, 0);
		chk("rng", ready_lamp_g ^ ready_lamp_y, 1);
		supply_range_err <= 1'h0;
		$display("lamps end");
	endtask
	task t_net;
		apb(1'h1, 8'h00, 32'h9);
		tick(2);
		g0 = net_lamp_g;
		chk("ntst", net_lamp_g ^ net_lamp_r, 1);
		chk("mtst", module_lamp_g ^ module_lamp_r, 1);
		tick(4);
		chk("blink", net_lamp_g, !g0);
		apb(1'h1, 8'h00, 32'h41);
		tick(2);
		chk("dup", {net_lamp_g, net_lamp_r}, 2'h1);
		apb(1'h1, 8'h00, 32'h11);
		tick(2);
		chk("conn", {net_lamp_g, net_lamp_r}, 2'h2);
		apb(1'h1, 8'h00, 32'h81);
		tick(2);
		g0 = net_lamp_r;
		tick(4);
		chk("tmo", {net_lamp_g, net_lamp_r}, {1'b0, !g0});
		apb(1'h1, 8'h00, 32'h21);
		tick(2);
		g0 = net_lamp_g;
		chk("mflash", module_lamp_g, g0);
		tick(4);
		chk("ipcfg", {net_lamp_g, module_lamp_g}, {!g0, !g0});
		apb(1'h1, 8'h00, 32'h701);
		tick(2);
		g0 = module_lamp_r;
		tick(4);
		chk("unrec", {module_lamp_g, module_lamp_r}, {1'b0, !g0});
		apb(1'h1, 8'h00, 32'h301);
		tick(2);
		chk("rec", {module_lamp_g, module_lamp_r}, 2'h1);
		apb(1'h1, 8'h00, 32'h101);
		tick(2);
		chk("mgreen", {module_lamp_g, module_lamp_r}, 2'h2);
		apb(1'h0, 8'hFC, 32'h0);
		chk("err", e, 1);
		chk("rd0", q, 0);
		chk("prdy", pready, 1);
		$display("net end");
	endtask
	initial begin
		t_codes();
		t_fixed();
		t_clear();
		t_factory();
		t_reserved();
		t_chan();
		t_lamps();
		t_net();
		close_out();
	end
endmodule // tb_config_switch_status_lamps
